// [dv/dmm_xmem_model.sv]
// Behavioural external data memory on the multiplexed port 0 and port 2 bus.
`timescale 1ns/1ps
module dmm_xmem_model (
   // Clock.
   input  wire logic        ref_clk,
   // Bus pins from the core.
   input  wire logic        ale,
   input  wire logic [7:0]  p0_out,
   input  wire logic        p0_oe,
   input  wire logic [7:0]  p2_out,
   input  wire logic        p2_oe,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   // Slow answer: read data appears one cycle after the strobe falls.
   input  wire logic        lag,
   // Memory drive onto port 0 and the address it latched.
   output logic      [7:0]  drv_data,
   output logic      [15:0] addr_q
);
   logic [7:0] mem [0:65535];  // Storage cells.
   logic [7:0] wbuf_q;         // Data seen while the write strobe is low.
   logic       wr_q;           // Write strobe one cycle late.
   logic       rd_q;           // Read active one cycle late.
   logic [7:0] last_q;         // Last byte put on port 0.
   logic       drive;          // Memory drives port 0.

   initial last_q = 8'h00;

   // Latch the address; with port 2 idle the upper byte reads as page zero.
   always @(posedge ref_clk) begin
      if (ale && p0_oe) begin
         addr_q <= {p2_oe ? p2_out : 8'h00, p0_out};
      end
      if (!wr_n) begin
         wbuf_q <= p0_out;
      end
      // Store once the write strobe rises again.
      if (wr_n && !wr_q) begin
         mem[addr_q] <= wbuf_q;
      end
      wr_q <= wr_n;
      rd_q <= !rd_n;
      if (drive) begin
         last_q <= drv_data;
      end
   end

   // Read data while selected; released, the bus shows the inverse of the last byte.
   assign drive    = !rd_n && (!lag || rd_q);
   assign drv_data = drive ? mem[addr_q] : ~last_q;
endmodule // dmm_xmem_model

// [dv/tb_top.sv]
// Self-checking bench for the data memory map and boot start block.
`timescale 1ns/1ps
module tb_top;
   localparam int                 XLIM  = 1792;                 // On-chip auxiliary RAM bytes.
   localparam dmm_pkg::dmm_kind_t K_DIR = dmm_pkg::ACC_DIRECT;   // Access kind shorthands.
   localparam dmm_pkg::dmm_kind_t K_IND = dmm_pkg::ACC_INDIRECT;
   localparam dmm_pkg::dmm_kind_t K_STK = dmm_pkg::ACC_STACK;
   localparam dmm_pkg::dmm_kind_t K_RI  = dmm_pkg::ACC_EXT_RI;
   localparam dmm_pkg::dmm_kind_t K_PTR = dmm_pkg::ACC_EXT_PTR;
   logic              ref_clk, rst, power_up, boot_status;   // Clock, reset, power and boot pins.
   logic [7:0]        boot_vector;                           // Boot vector high byte.
   logic              program_store_strobe_n;                // Program store strobe pin.
   logic              req_valid, code_move_active;           // Request present, code move active.
   dmm_pkg::dmm_req_t req;                                   // Request body.
   logic              busy_q, rsp_valid_q, p0_oe_q, p2_oe_q; // Core status and drive enables.
   logic [7:0]        rsp_data_q, p0_in, p0_out_q, p2_out_q; // Answer data and port values.
   logic              rd_n_q, wr_n_q, ale_q;                 // Bus strobes.
   logic [15:0]       start_addr_q, xm_addr;                 // Start address, latched bus address.
   logic              start_valid_q, weak_pull_q, lag;       // Start pulse, pull-ups, slow memory.
   logic [7:0]        xm_data;                               // Memory drive onto port 0.
   int                n_fail, cmp_count, stb, last_stb;      // Counters.
   logic              last_busy;                             // Busy seen one cycle after the take.

   // Port 0 wire: the core wins while it drives, otherwise the memory.
   assign p0_in = p0_oe_q ? p0_out_q : xm_data;

   dmm_core #(.XRAM_BYTES(XLIM)) dut_u (
      .ref_clk(ref_clk), .rst(rst), .power_up(power_up), .boot_status(boot_status),
      .boot_vector(boot_vector), .program_store_strobe_n(program_store_strobe_n),
      .req_valid(req_valid), .req(req), .code_move_active(code_move_active), .busy_q(busy_q),
      .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .p0_in(p0_in), .p0_out_q(p0_out_q),
      .p0_oe_q(p0_oe_q), .p2_out_q(p2_out_q), .p2_oe_q(p2_oe_q), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q),
      .ale_q(ale_q), .start_addr_q(start_addr_q), .start_valid_q(start_valid_q),
      .weak_pull_q(weak_pull_q));

   dmm_xmem_model xm_u (
      .ref_clk(ref_clk), .ale(ale_q), .p0_out(p0_out_q), .p0_oe(p0_oe_q), .p2_out(p2_out_q),
      .p2_oe(p2_oe_q), .rd_n(rd_n_q), .wr_n(wr_n_q), .lag(lag), .drv_data(xm_data), .addr_q(xm_addr));

   // Clock and a running count of cycles with a bus strobe low.
   initial ref_clk = 1'b0;
   always #4 ref_clk = ~ref_clk;
   always @(negedge ref_clk) stb <= stb + int'(!rd_n_q) + int'(!wr_n_q);

   // Compare and count.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Print the counts and the verdict, then stop.
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A wait that ran out ends the run.
   task automatic hang(input string what);
      n_fail++;
      $display("MISMATCH t=%0t no %s", $time, what);
      give_verdict();
   endtask

   // One access on the core port; notes the strobe cycles it caused.
   task automatic acc(input dmm_pkg::dmm_kind_t k, input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int i;
      int s0;
      @(negedge ref_clk);
      s0 = stb;
      req_valid = 1'b1;
      req = '{kind: k, we: w, addr: a, wdata: d};
      @(negedge ref_clk);
      req_valid = 1'b0;
      last_busy = busy_q;
      for (i = 0; i < 20 && rsp_valid_q !== 1'b1; i++) begin
         @(negedge ref_clk);
      end
      if (i == 20) begin
         hang("answer");
      end
      q = rsp_data_q;
      last_stb = stb - s0;
   endtask

   task automatic wr(input dmm_pkg::dmm_kind_t k, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(k, 1'b1, a, d, q);
   endtask

   // Read and compare under a mask.
   task automatic rdc(input dmm_pkg::dmm_kind_t k, input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
      logic [7:0] q;
      acc(k, 1'b0, a, 8'h00, q);
      check({8'h00, q & m}, {8'h00, e});
   endtask

   // Whether the last access ran strobes and held the port busy.
   task automatic stbck(input logic e);
      check({14'h0, last_stb != 0, last_busy}, {14'h0, e, e});
   endtask

   // Select a pointer and load it.
   task automatic ptr(input logic s, input logic [7:0] hi, input logic [7:0] lo);
      wr(K_DIR, dmm_pkg::OFS_PSEL, {7'h00, s});
      wr(K_DIR, dmm_pkg::OFS_DPL, lo);
      wr(K_DIR, dmm_pkg::OFS_DPH, hi);
   endtask

   // Reset with given boot inputs and check the start address.
   task automatic reset_dut(input logic st, input logic ps_n, input logic [15:0] e);
      int i;
      @(negedge ref_clk);
      boot_status = st;
      program_store_strobe_n = ps_n;
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      rst = 1'b0;
      for (i = 0; i < 8 && start_valid_q !== 1'b1; i++) begin
         @(negedge ref_clk);
      end
      if (i == 8) begin
         hang("start pulse");
      end
      check(start_addr_q, e);
   endtask

   // Count latch strobe highs over eight cycles after a settling gap.
   task automatic ale_cnt(input logic [3:0] e);
      logic [3:0] n;
      n = 4'h0;
      repeat (2) @(negedge ref_clk);
      repeat (8) begin
         @(negedge ref_clk);
         n = n + {3'b000, ale_q};
      end
      check({12'h000, n}, {12'h000, e});
   endtask

   initial begin
      rst = 1'b1;
      power_up = 1'b1;
      boot_status = 1'b0;
      boot_vector = 8'h5c;
      program_store_strobe_n = 1'b1;
      req_valid = 1'b0;
      req = '0;
      code_move_active = 1'b0;
      lag = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      stb = 0;
      reset_dut(1'b0, 1'b1, 16'h0000);
      repeat (4) @(negedge ref_clk);
      power_up = 1'b0;
      check({15'h0, weak_pull_q}, 16'h0001);
      rdc(K_DIR, dmm_pkg::OFS_XCTL, 8'h00);
      rdc(K_DIR, dmm_pkg::OFS_PSEL, 8'h00);
      rdc(K_DIR, dmm_pkg::OFS_POWER_CONTROL_REGISTER, 8'h10, 8'h10);
      $display("test reset done");
      wr(K_DIR, 8'h10, 8'h3c);
      rdc(K_IND, 8'h10, 8'h3c);
      wr(K_IND, 8'hc0, 8'h5a);
      rdc(K_IND, 8'hc0, 8'h5a);
      rdc(K_DIR, 8'hc0, 8'h00);
      wr(K_STK, 8'hd0, 8'h77);
      rdc(K_IND, 8'hd0, 8'h77);
      $display("test internal done");
      wr(K_DIR, dmm_pkg::OFS_PSEL, 8'hff);
      rdc(K_DIR, dmm_pkg::OFS_PSEL, 8'h09);
      wr(K_DIR, dmm_pkg::OFS_PSEL, 8'h0a);
      rdc(K_DIR, dmm_pkg::OFS_PSEL, 8'h08);
      ptr(1'b0, 8'h00, 8'h12);
      ptr(1'b1, 8'h56, 8'h78);
      rdc(K_DIR, dmm_pkg::OFS_DPH, 8'h56);
      wr(K_DIR, dmm_pkg::OFS_PSEL, 8'h00);
      rdc(K_DIR, dmm_pkg::OFS_DPL, 8'h12);
      wr(K_DIR, dmm_pkg::OFS_PSEL, 8'h01);
      $display("test pointers done");
      wr(K_PTR, 8'h00, 8'ha5);
      stbck(1'b1);
      check(xm_addr, 16'h5678);
      rdc(K_PTR, 8'h00, 8'ha5);
      lag = 1'b1;
      wr(K_RI, 8'h21, 8'hc3);
      check(xm_addr, 16'h0021);
      rdc(K_RI, 8'h21, 8'hc3);
      lag = 1'b0;
      $display("test off-chip done");
      wr(K_DIR, dmm_pkg::OFS_XCTL, 8'h02);
      rdc(K_DIR, dmm_pkg::OFS_XCTL, 8'h02);
      ptr(1'b0, 8'h00, 8'h12);
      wr(K_PTR, 8'h00, 8'he1);
      stbck(1'b0);
      rdc(K_PTR, 8'h00, 8'he1);
      wr(K_RI, 8'h21, 8'h99);
      stbck(1'b0);
      rdc(K_RI, 8'h21, 8'h99);
      ptr(1'b0, 8'h06, 8'hff);
      wr(K_PTR, 8'h00, 8'h11);
      stbck(1'b0);
      ptr(1'b0, 8'h07, 8'h00);
      wr(K_PTR, 8'h00, 8'h22);
      stbck(1'b1);
      check(xm_addr, 16'h0700);
      $display("test on-chip done");
      ale_cnt(4'h4);
      wr(K_DIR, dmm_pkg::OFS_XCTL, 8'h03);
      ale_cnt(4'h0);
      code_move_active = 1'b1;
      ale_cnt(4'h4);
      code_move_active = 1'b0;
      $display("test latch strobe done");
      wr(K_DIR, dmm_pkg::OFS_POWER_CONTROL_REGISTER, 8'h00);
      rdc(K_DIR, dmm_pkg::OFS_POWER_CONTROL_REGISTER, 8'h00, 8'h10);
      reset_dut(1'b1, 1'b1, 16'h5c00);
      rdc(K_DIR, 8'h10, 8'h3c);
      rdc(K_DIR, dmm_pkg::OFS_POWER_CONTROL_REGISTER, 8'h00, 8'h10);
      rdc(K_DIR, dmm_pkg::OFS_XCTL, 8'h00);
      reset_dut(1'b0, 1'b0, 16'h5c00);
      reset_dut(1'b0, 1'b1, 16'h0000);
      $display("test boot done");
      give_verdict();
   end
endmodule // tb_top

// [hdl/dmm_core.sv]
// Data memory decoder, off-chip bus sequencer, pointers and boot start.
`timescale 1ns/1ps
module dmm_core #(
   parameter int XRAM_BYTES = 1792,
   parameter int STROBE_CYC = dmm_pkg::STROBE_CYC
) (
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Power and boot inputs.
   input  wire logic             power_up,
   input  wire logic             boot_status,
   input  wire logic [7:0]       boot_vector,
   input  wire logic             program_store_strobe_n,
   // Core access port.
   input  wire logic             req_valid,
   input  wire dmm_pkg::dmm_req_t req,
   input  wire logic             code_move_active,
   output logic                  busy_q,
   output logic                  rsp_valid_q,
   output logic [7:0]            rsp_data_q,
   // Off-chip bus pins.
   input  wire logic [7:0]       p0_in,
   output logic [7:0]            p0_out_q,
   output logic                  p0_oe_q,
   output logic [7:0]            p2_out_q,
   output logic                  p2_oe_q,
   output logic                  rd_n_q,
   output logic                  wr_n_q,
   output logic                  ale_q,
   // Start and port status.
   output logic [15:0]           start_addr_q,
   output logic                  start_valid_q,
   output logic                  weak_pull_q
);

   localparam int AW = $clog2(XRAM_BYTES);
   localparam logic [16:0] XLIM = 17'(XRAM_BYTES);

   // Synchronised pins.
   logic [7:0] p0_s;        // Port 0 read data.
   logic       program_store_strobe_n_s_n;    // Program store strobe level.
   logic       por_s;       // Power-up indication.

   // Register state.
   logic        internal_xram_enable_q;  // Auxiliary RAM enable.
   logic        latch_strobe_suppress_q; // Latch strobe suppress.
   logic        pointer_select_q;        // Pointer select.
   logic        user_flag_q;             // General user flag.
   logic        power_on_flag_q;         // Power-on flag.
   logic [15:0] data_pointer_q [2];      // Two data pointers.

   // Memories.
   logic [7:0] iram [256];               // Direct and indirect RAM.
   logic [7:0] xram [XRAM_BYTES];        // On-chip auxiliary RAM.

   // Bus sequencer state.
   dmm_pkg::dmm_state_t state_q;
   logic [7:0]  cnt_q;                   // Strobe cycle counter.
   logic        lat_we_q;                // Write flag of the bus cycle.
   logic [7:0]  lat_data_q;              // Write data of the bus cycle.
   logic        rst_q;                   // Delayed reset for release edge.

   // Decode results.
   logic        accept;
   logic        is_sfr;
   logic        is_iram;
   logic        is_xram;
   logic        is_ext;
   logic        drive_p2;
   logic [15:0] ext_addr;
   logic [15:0] sel_ptr;
   logic [7:0]  sfr_rdata;
   logic        reset_release;

   // Synchronisers for pins from outside the clock domain.
   dmm_sync #(.W(8)) u_sync_p0 (
      .ref_clk (ref_clk),
      .d       (p0_in),
      .q       (p0_s)
   );
   dmm_sync #(.W(1)) u_sync_program_store_strobe_n (
      .ref_clk (ref_clk),
      .d       (program_store_strobe_n),
      .q       (program_store_strobe_n_s_n)
   );
   dmm_sync #(.W(1)) u_sync_por (
      .ref_clk (ref_clk),
      .d       (power_up),
      .q       (por_s)
   );

   // The selected pointer feeds every pointer access.
   assign sel_ptr = data_pointer_q[pointer_select_q];

   assign accept        = req_valid && (state_q == dmm_pkg::ST_IDLE);
   assign reset_release = rst_q && !rst;

   // Address decode for one request.
   always_comb begin
      is_sfr   = 1'b0;
      is_iram  = 1'b0;
      is_xram  = 1'b0;
      is_ext   = 1'b0;
      drive_p2 = 1'b0;
      ext_addr = {8'h00, req.addr};
      case (req.kind)
         dmm_pkg::ACC_DIRECT: begin
            // Lower half is RAM, upper half the registers.
            if (req.addr < dmm_pkg::SFR_BASE) begin
               is_iram = 1'b1;
            end else begin
               is_sfr = 1'b1;
            end
         end
         dmm_pkg::ACC_INDIRECT,
         dmm_pkg::ACC_STACK: begin
            // Indirect and stack accesses reach all 256 bytes, never registers.
            is_iram = 1'b1;
         end
         dmm_pkg::ACC_EXT_RI: begin
            // An 8-bit index always falls inside the on-chip range.
            if (internal_xram_enable_q) begin
               is_xram = 1'b1;
            end else begin
               is_ext = 1'b1;
            end
         end
         dmm_pkg::ACC_EXT_PTR: begin
            ext_addr = sel_ptr;
            drive_p2 = 1'b1;
            if (internal_xram_enable_q && ({1'b0, sel_ptr} < XLIM)) begin
               is_xram = 1'b1;
            end else begin
               is_ext = 1'b1;
            end
         end
         default: begin
            is_iram = 1'b0;
         end
      endcase
   end

   // Register read mux; reserved and unmapped bits read as zero.
   always_comb begin
      case (req.addr)
         dmm_pkg::OFS_XCTL: begin
            sfr_rdata = {6'h00, internal_xram_enable_q, latch_strobe_suppress_q};
         end
         dmm_pkg::OFS_PSEL: begin
            // Bit 2 is a fixed zero so an increment flips the select bit.
            sfr_rdata = {4'h0, user_flag_q, 1'b0, 1'b0, pointer_select_q};
         end
         dmm_pkg::OFS_POWER_CONTROL_REGISTER: begin
            sfr_rdata = {3'h0, power_on_flag_q, 4'h0};
         end
         dmm_pkg::OFS_DPL: begin
            sfr_rdata = sel_ptr[7:0];
         end
         dmm_pkg::OFS_DPH: begin
            sfr_rdata = sel_ptr[15:8];
         end
         default: begin
            sfr_rdata = 8'h00;
         end
      endcase
   end

   // Control register writes.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         internal_xram_enable_q  <= dmm_pkg::XCTL_RST[dmm_pkg::XCTL_EN_BIT];
         latch_strobe_suppress_q <= dmm_pkg::XCTL_RST[dmm_pkg::XCTL_SUP_BIT];
         pointer_select_q        <= dmm_pkg::PSEL_RST[dmm_pkg::PSEL_SEL_BIT];
         user_flag_q             <= dmm_pkg::PSEL_RST[dmm_pkg::PSEL_FLAG_BIT];
      end else if (accept && is_sfr && req.we) begin
         if (req.addr == dmm_pkg::OFS_XCTL) begin
            internal_xram_enable_q  <= req.wdata[dmm_pkg::XCTL_EN_BIT];
            latch_strobe_suppress_q <= req.wdata[dmm_pkg::XCTL_SUP_BIT];
         end
         if (req.addr == dmm_pkg::OFS_PSEL) begin
            pointer_select_q <= req.wdata[dmm_pkg::PSEL_SEL_BIT];
            user_flag_q      <= req.wdata[dmm_pkg::PSEL_FLAG_BIT];
         end
      end
   end

   // Data pointer bytes, written through the selected pointer.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_pointer_q[0] <= 16'h0000;
         data_pointer_q[1] <= 16'h0000;
      end else if (accept && is_sfr && req.we) begin
         if (req.addr == dmm_pkg::OFS_DPL) begin
            data_pointer_q[pointer_select_q][7:0] <= req.wdata;
         end
         if (req.addr == dmm_pkg::OFS_DPH) begin
            data_pointer_q[pointer_select_q][15:8] <= req.wdata;
         end
      end
   end

   // Power-on flag: untouched by reset, set wins over a software clear.
   always_ff @(posedge ref_clk) begin
      if (por_s) begin
         power_on_flag_q <= 1'b1;
      end else if (accept && is_sfr && req.we && (req.addr == dmm_pkg::OFS_POWER_CONTROL_REGISTER)) begin
         power_on_flag_q <= req.wdata[dmm_pkg::POWER_CONTROL_REGISTER_POF_BIT];
      end
   end

   // RAM writes; the arrays have no reset so contents survive it.
   always_ff @(posedge ref_clk) begin
      if (accept && req.we && is_iram) begin
         iram[req.addr] <= req.wdata;
      end
      if (accept && req.we && is_xram) begin
         xram[ext_addr[AW-1:0]] <= req.wdata;
      end
   end

   // Answer path: internal accesses answer next cycle, bus cycles at their end.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= 8'h00;
      end else if (accept && !is_ext) begin
         rsp_valid_q <= 1'b1;
         if (is_sfr) begin
            rsp_data_q <= sfr_rdata;
         end else if (is_xram) begin
            rsp_data_q <= xram[ext_addr[AW-1:0]];
         end else begin
            rsp_data_q <= iram[req.addr];
         end
      end else if (state_q == dmm_pkg::ST_STROBE && cnt_q == 8'(STROBE_CYC - 1)) begin
         rsp_valid_q <= 1'b1;
         rsp_data_q  <= p0_s;
      end else begin
         rsp_valid_q <= 1'b0;
      end
   end

   // Off-chip bus sequencer: address phase, then read or write strobe.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q    <= dmm_pkg::ST_IDLE;
         busy_q     <= 1'b0;
         cnt_q      <= 8'h00;
         lat_we_q   <= 1'b0;
         lat_data_q <= 8'h00;
         p0_out_q   <= 8'h00;
         p0_oe_q    <= 1'b0;
         p2_out_q   <= 8'h00;
         p2_oe_q    <= 1'b0;
         rd_n_q     <= 1'b1;
         wr_n_q     <= 1'b1;
      end else begin
         case (state_q)
            dmm_pkg::ST_IDLE: begin
               // Only off-chip requests touch the pins.
               if (accept && is_ext) begin
                  state_q    <= dmm_pkg::ST_ADDR;
                  busy_q     <= 1'b1;
                  lat_we_q   <= req.we;
                  lat_data_q <= req.wdata;
                  p0_out_q   <= ext_addr[7:0];
                  p0_oe_q    <= 1'b1;
                  p2_out_q   <= ext_addr[15:8];
                  p2_oe_q    <= drive_p2;
               end
            end
            dmm_pkg::ST_ADDR: begin
               // Port 0 turns from address to data.
               state_q <= dmm_pkg::ST_STROBE;
               cnt_q   <= 8'h00;
               if (lat_we_q) begin
                  p0_out_q <= lat_data_q;
                  wr_n_q   <= 1'b0;
               end else begin
                  p0_oe_q <= 1'b0;
                  rd_n_q  <= 1'b0;
               end
            end
            dmm_pkg::ST_STROBE: begin
               // Hold the strobe for the full width, then release everything.
               if (cnt_q == 8'(STROBE_CYC - 1)) begin
                  state_q <= dmm_pkg::ST_IDLE;
                  busy_q  <= 1'b0;
                  rd_n_q  <= 1'b1;
                  wr_n_q  <= 1'b1;
                  p0_oe_q <= 1'b0;
                  p2_oe_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + 8'h01;
               end
            end
            default: begin
               state_q <= dmm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Address latch strobe: half-rate when not suppressed, else only on moves.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ale_q <= 1'b0;
      end else if (accept && is_ext) begin
         ale_q <= 1'b1;
      end else if (state_q != dmm_pkg::ST_IDLE) begin
         ale_q <= 1'b0;
      end else if (!latch_strobe_suppress_q || code_move_active) begin
         ale_q <= ~ale_q;
      end else begin
         ale_q <= 1'b0;
      end
   end

   // Start address chosen at reset release; the reset source holds reset long enough.
   always_ff @(posedge ref_clk) begin
      rst_q <= rst;
      if (rst) begin
         start_addr_q  <= dmm_pkg::RESET_PC;
         start_valid_q <= 1'b0;
      end else if (reset_release) begin
         start_valid_q <= 1'b1;
         if (!program_store_strobe_n_s_n || boot_status) begin
            start_addr_q <= {boot_vector, dmm_pkg::BOOT_LOW};
         end else begin
            start_addr_q <= dmm_pkg::RESET_PC;
         end
      end else begin
         start_valid_q <= 1'b0;
      end
   end

   // Weak pull-ups come on with the internal reset and stay on.
   always_ff @(posedge ref_clk) begin
      if (rst || por_s) begin
         weak_pull_q <= 1'b1;
      end else begin
         weak_pull_q <= weak_pull_q;
      end
   end

   // Checks of the block's own behaviour.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_int_one_cycle: assert property (
      accept && (is_iram || is_sfr) |=> rsp_valid_q && !busy_q)
      else $error("internal access did not answer in one cycle");

   a_xram_quiet: assert property (
      accept && is_xram |=> (rd_n_q && wr_n_q && !p0_oe_q && !p2_oe_q && !busy_q) [*2])
      else $error("on-chip auxiliary access touched the bus");

   a_ext_read_seq: assert property (
      accept && is_ext && !req.we |=> ale_q && p0_oe_q ##1 (!rd_n_q && wr_n_q) [*4] ##1 rd_n_q && rsp_valid_q)
      else $error("off-chip read cycle malformed");

   a_ri_off_p2: assert property (
      accept && is_ext && req.kind == dmm_pkg::ACC_EXT_RI |=> !p2_oe_q && p0_out_q == $past(req.addr))
      else $error("index move drove port 2 or wrong address");

   a_ptr_addr_out: assert property (
      accept && is_ext && req.kind == dmm_pkg::ACC_EXT_PTR |=> p2_oe_q && {p2_out_q, p0_out_q} == $past(sel_ptr))
      else $error("pointer move address wrong");

   a_ri_internal: assert property (
      accept && internal_xram_enable_q && req.kind == dmm_pkg::ACC_EXT_RI |=> rd_n_q && wr_n_q && !busy_q)
      else $error("index move went off-chip while enabled");

   a_ale_toggle: assert property (
      state_q == dmm_pkg::ST_IDLE && !latch_strobe_suppress_q && !(accept && is_ext) |=> ale_q != $past(ale_q))
      else $error("latch strobe not free running");

   a_ale_quiet: assert property (
      state_q == dmm_pkg::ST_IDLE && latch_strobe_suppress_q && !code_move_active && !(accept && is_ext) |=> !ale_q)
      else $error("latch strobe pulsed while suppressed");

   a_zero_bit_two: assert property (
      accept && is_sfr && !req.we && req.addr == dmm_pkg::OFS_PSEL |=> !rsp_data_q[2])
      else $error("select register bit 2 not zero");

   a_stack_internal: assert property (
      accept && req.kind == dmm_pkg::ACC_STACK |=> rsp_valid_q && rd_n_q && wr_n_q && !busy_q)
      else $error("stack access left internal RAM");

   a_pof_set: assert property (
      por_s |=> power_on_flag_q [*2])
      else $error("power-on flag not set");

   a_boot_pick: assert property (
      reset_release |=> start_valid_q && start_addr_q ==
         ((!$past(program_store_strobe_n_s_n) || $past(boot_status)) ? {$past(boot_vector), 8'h00} : 16'h0000))
      else $error("start address wrong");

endmodule // dmm_core

// [hdl/dmm_pkg.sv]
// Constants and types for the data memory map and boot start logic.
// How it works
// - Direct area 00H-7FH holds internal RAM.
// - Indirect area covers all 256 RAM bytes.
// - Direct upper range reaches registers; indirect reaches RAM.
// - On-chip auxiliary RAM sits at bottom.
// - In-range auxiliary access leaves bus pins quiet.
// - Pointer access beyond limit runs bus cycle.
// - Enable clear sends every external move off-chip.
// - Index-register moves use internal RAM when enabled.
// - Index-register off-chip moves drive 8-bit address.
// - Pointer off-chip moves drive full 16-bit address.
// - Latch strobe free-running unless suppress bit set.
// - Stack reaches only the 256-byte RAM.
// - Select bit chooses one of two pointers.
// - Select register bit 2 always reads zero.
// - Reset leaves RAM contents unchanged.
// - Power-up sets flag until software clears.
// - Start at 0000H unless strobe low/status set.
// - Boot address is vector then 00H.
// - Power-up reset pulls port pins weakly high.
// - Unimplemented register bits read as zero.
package dmm_pkg;

   // Register offsets in the special function space.
   localparam logic [7:0] OFS_XCTL = 8'h8e;
   localparam logic [7:0] OFS_PSEL = 8'ha2;
   localparam logic [7:0] OFS_POWER_CONTROL_REGISTER = 8'h87;
   localparam logic [7:0] OFS_DPL  = 8'h82;
   localparam logic [7:0] OFS_DPH  = 8'h83;

   // Field positions.
   localparam int XCTL_EN_BIT   = 1;
   localparam int XCTL_SUP_BIT  = 0;
   localparam int PSEL_SEL_BIT  = 0;
   localparam int PSEL_FLAG_BIT = 3;
   localparam int POWER_CONTROL_REGISTER_POF_BIT  = 4;

   // Reset values.
   localparam logic [7:0]  XCTL_RST  = 8'h00;
   localparam logic [7:0]  PSEL_RST  = 8'h00;
   localparam logic [15:0] RESET_PC  = 16'h0000;
   localparam logic [7:0]  BOOT_LOW  = 8'h00;

   // Address map limits.
   localparam logic [7:0] SFR_BASE = 8'h80;

   // Off-chip strobe width: time in ns, clock in MHz, count rounded up.
   localparam int CLK_MHZ    = 125;
   localparam int STROBE_NS  = 32;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;

   // Kind of data access the core asks for.
   typedef enum logic [2:0] {
      ACC_DIRECT,
      ACC_INDIRECT,
      ACC_STACK,
      ACC_EXT_RI,
      ACC_EXT_PTR
   } dmm_kind_t;

   // One access request.
   typedef struct packed {
      dmm_kind_t  kind;
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dmm_req_t;

   // Off-chip bus cycle states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_STROBE
   } dmm_state_t;

endpackage

// [hdl/dmm_sync.sv]
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module dmm_sync #(
   parameter int W = 1
) (
   // Clock.
   input  wire logic         ref_clk,
   // Asynchronous input and its synchronised copy.
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   // First stage, read only by the second stage.
   logic [W-1:0] meta_q;

   // Plain two-stage chain with no reset.
   always_ff @(posedge ref_clk) begin
      meta_q <= d;
      q      <= meta_q;
   end

endmodule // dmm_sync
